// *** src/ccl_pkg.sv ***
// constants and types of the comparator control logic
package ccl_pkg;
   localparam int          BUS_AW        = 4;
   localparam logic [3:0]  CTRL_OFS      = 4'h0;
   localparam logic [3:0]  ISTAT_OFS     = 4'h4;
   localparam logic [3:0]  IMASK_OFS     = 4'h8;
   localparam int          EN_BIT        = 7;
   localparam int          REF_BIT       = 6;
   localparam int          FLAG_BIT      = 5;
   localparam int          IE_BIT        = 4;
   localparam int          LVL_BIT       = 3;
   localparam int          OPE_BIT       = 2;
   localparam int          MODE_LSB      = 0;
   localparam int          ISTAT_EV_BIT  = 0;
   localparam logic [7:0]  CTRL_RST      = 8'h00;
   localparam logic [1:0]  MODE_FALL0    = 2'h0;
   localparam logic [1:0]  MODE_RISE     = 2'h1;
   localparam logic [1:0]  MODE_FALL2    = 2'h2;
   localparam logic [1:0]  MODE_BOTH     = 2'h3;
   localparam int          SYNC_STAGES   = 3;

   typedef struct packed {
      logic       enable;
      logic       ref_sel;
      logic       irq_en;
      logic       pin_en;
      logic [1:0] edge_sel;
   } ccl_ctrl_t;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [3:0]  sel;
      logic [3:0]  adr;
      logic [31:0] dat;
   } ccl_wb_req_t;
endpackage

// *** src/ccl_top.sv ***
// comparator control and status logic with a classic wishbone slave
//
// Added by the designer: the register addresses and the Wishbone slave port.
`timescale 1ns/10ps

module ccl_top (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        cmp_level_i,
   output logic             comparator_enable_o,
   output logic             reference_select_o,
   output logic             inverting_select_o,
   output logic             comparator_out_pin_o,
   output logic             comparator_out_pin_oe_o,
   output logic             irq_o
);
   ccl_pkg::ccl_ctrl_t   ctrl;
   ccl_pkg::ccl_wb_req_t req;
   logic                 compare_event_flag;
   logic [2:0]           sync;
   logic                 filt;
   logic                 filt_d;
   logic                 en_d;
   logic                 rise;
   logic                 fall;
   logic                 cmp_event;
   logic                 wr_take;
   logic                 rd_take;
   logic                 flag_clr;
   logic                 lvl_view;
   logic                 wr_ctrl;
   logic                 wr_istat;
   logic                 wr_imask;
   logic                 rd_ctrl;

   // edge decode used only by the flag logic; the checks decode edges themselves
   function automatic logic ccl_edge_hit(logic [1:0] sel, logic up, logic down);
      logic hit;
      hit = 1'b0;
      unique case (sel)
         ccl_pkg::MODE_RISE:  hit = up;
         ccl_pkg::MODE_BOTH:  hit = up || down;
         ccl_pkg::MODE_FALL0: hit = down;
         ccl_pkg::MODE_FALL2: hit = down;
      endcase
      return hit;
   endfunction

   // register image of the control byte
   function automatic logic [7:0] ccl_ctrl_byte(ccl_pkg::ccl_ctrl_t c, logic flag, logic lvl);
      return {c.enable, c.ref_sel, flag, c.irq_en, lvl, c.pin_en, c.edge_sel};
   endfunction

   if (ccl_pkg::SYNC_STAGES != 3) begin
      $error("sync depth must be three");
   end

   assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
                  adr: wb_adr_i, dat: wb_dat_i};

   // bus: one wait state, ack drops the cycle after it is given
   assign wr_take = req.cyc && req.stb && req.we && !wb_ack_o;
   assign rd_take = req.cyc && req.stb && !req.we && !wb_ack_o;

   // one decode per register, shared by every write consumer
   assign wr_ctrl  = wr_take && req.sel[0] && (req.adr == ccl_pkg::CTRL_OFS);
   assign wr_istat = wr_take && req.sel[0] && (req.adr == ccl_pkg::ISTAT_OFS);
   assign wr_imask = wr_take && req.sel[0] && (req.adr == ccl_pkg::IMASK_OFS);
   assign rd_ctrl  = rd_take && (req.adr == ccl_pkg::CTRL_OFS);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= req.cyc && req.stb && !wb_ack_o;
      end
   end

   // control fields, byte lane 0 only
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl <= '{enable: ccl_pkg::CTRL_RST[ccl_pkg::EN_BIT],
                   ref_sel: ccl_pkg::CTRL_RST[ccl_pkg::REF_BIT],
                   irq_en: ccl_pkg::CTRL_RST[ccl_pkg::IE_BIT],
                   pin_en: ccl_pkg::CTRL_RST[ccl_pkg::OPE_BIT],
                   edge_sel: ccl_pkg::CTRL_RST[1:0]};
      end else if (wr_ctrl) begin
         ctrl.enable   <= req.dat[ccl_pkg::EN_BIT];
         ctrl.ref_sel  <= req.dat[ccl_pkg::REF_BIT];
         ctrl.irq_en   <= req.dat[ccl_pkg::IE_BIT];
         ctrl.pin_en   <= req.dat[ccl_pkg::OPE_BIT];
         ctrl.edge_sel <= req.dat[ccl_pkg::MODE_LSB +: 2];
      end else if (wr_imask) begin
         ctrl.irq_en   <= req.dat[ccl_pkg::ISTAT_EV_BIT];
      end
   end

   // three-stage synchroniser; first stage feeds only the second
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync <= 3'h0;
      end else begin
         sync <= {sync[1:0], cmp_level_i};
      end
   end

   // a change counts once stages two and three agree
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         filt   <= 1'b0;
         filt_d <= 1'b0;
      end else begin
         if (sync[1] == sync[2]) begin
            filt <= sync[2];
         end
         filt_d <= filt;
      end
   end

   // enable delayed one cycle, masks the first enabled cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         en_d <= 1'b0;
      end else begin
         en_d <= ctrl.enable;
      end
   end

   assign rise = filt && !filt_d;
   assign fall = !filt && filt_d;

   // en_d masks the first enabled cycle so a stale level is no event
   always_comb begin
      cmp_event = ccl_edge_hit(ctrl.edge_sel, rise, fall) && ctrl.enable && en_d;
   end

   // clear path: bit 5 of control or bit 0 of interrupt status
   assign flag_clr = (wr_ctrl && req.dat[ccl_pkg::FLAG_BIT]) ||
                     (wr_istat && req.dat[ccl_pkg::ISTAT_EV_BIT]);

   // set wins over a clear in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         compare_event_flag <= 1'b0;
      end else if (cmp_event) begin
         compare_event_flag <= 1'b1;
      end else if (flag_clr) begin
         compare_event_flag <= 1'b0;
      end
   end

   assign lvl_view = ctrl.enable && filt;

   // read data
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0;
      end else if (rd_take) begin
         unique case (req.adr)
            ccl_pkg::CTRL_OFS:
               wb_dat_o <= {24'h0, ccl_ctrl_byte(ctrl, compare_event_flag, lvl_view)};
            ccl_pkg::ISTAT_OFS: wb_dat_o <= {31'h0, compare_event_flag};
            ccl_pkg::IMASK_OFS: wb_dat_o <= {31'h0, ctrl.irq_en};
            default:            wb_dat_o <= 32'h0;
         endcase
      end
   end

   // output pin driven from a flop; oe follows the pin enable bit directly
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         comparator_out_pin_o <= 1'b0;
      end else begin
         comparator_out_pin_o <= lvl_view;
      end
   end

   assign comparator_out_pin_oe_o = ctrl.pin_en;
   assign comparator_enable_o     = ctrl.enable;
   assign reference_select_o      = ctrl.ref_sel;
   assign inverting_select_o      = 1'b0;
   assign irq_o                   = compare_event_flag && ctrl.irq_en;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   en_follows_a: assert property (wr_ctrl |=>
                                  comparator_enable_o == $past(req.dat[ccl_pkg::EN_BIT]))
      else $error("analog enable does not follow the written bit");
   ref_follows_a: assert property (wr_ctrl |=>
                                   reference_select_o == $past(req.dat[ccl_pkg::REF_BIT]))
      else $error("reference select does not follow the written bit");
   flag_sets_a: assert property (cmp_event |=> compare_event_flag)
      else $error("flag not set after compare event");
   flag_clears_a: assert property (flag_clr && !cmp_event |=> !compare_event_flag)
      else $error("flag not cleared by write of one");
   flag_holds_a: assert property (compare_event_flag && !flag_clr |=> compare_event_flag)
      else $error("flag lost without clear");
   irq_gate_a: assert property (irq_o == (compare_event_flag && ctrl.irq_en))
      else $error("interrupt does not match flag and enable");
   level_off_a: assert property (!ctrl.enable |-> !lvl_view ##1
                                 (ctrl.enable || !comparator_out_pin_o))
      else $error("level seen while disabled");
   pin_drive_a: assert property (wr_ctrl |=>
                                 comparator_out_pin_oe_o == $past(req.dat[ccl_pkg::OPE_BIT]))
      else $error("pin enable wrong");
   fall_mode_a: assert property (ctrl.enable && en_d && fall &&
                                 (ctrl.edge_sel == ccl_pkg::MODE_FALL0 ||
                                  ctrl.edge_sel == ccl_pkg::MODE_FALL2) |=> compare_event_flag)
      else $error("falling edge missed");
   rise_ignored_a: assert property (ctrl.edge_sel != ccl_pkg::MODE_RISE &&
                                    ctrl.edge_sel != ccl_pkg::MODE_BOTH && rise |-> !cmp_event)
      else $error("rising edge counted in falling mode");
   minus_fixed_a: assert property (inverting_select_o == 1'b0)
      else $error("inverting input moved");
   sync_lag_a: assert property ($rose(sync[2]) && sync[1] |=> filt)
      else $error("stable level not taken");
   no_event_off_a: assert property (!ctrl.enable |-> !cmp_event)
      else $error("event while disabled");
   ack_one_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered in one cycle");
   ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without a request");
   dat_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
      else $error("upper read data not zero");

   // read image, interrupt, output pin and output hold
   read_level_a: assert property (rd_ctrl |=>
                                  wb_dat_o[ccl_pkg::LVL_BIT] == $past(lvl_view))
      else $error("level bit read wrong");
   read_flag_a: assert property (rd_ctrl |=>
                                 wb_dat_o[ccl_pkg::FLAG_BIT] == $past(compare_event_flag))
      else $error("flag bit read wrong");
   read_off_a: assert property (rd_ctrl && !ctrl.enable |=> !wb_dat_o[ccl_pkg::LVL_BIT])
      else $error("level bit read while disabled");
   irq_off_a: assert property (!ctrl.irq_en |-> !irq_o)
      else $error("interrupt while masked");
   irq_on_a: assert property (compare_event_flag && ctrl.irq_en |-> irq_o)
      else $error("interrupt missing");
   pin_follow_a: assert property (comparator_out_pin_o == $past(lvl_view))
      else $error("pin does not follow the level");
   en_hold_a: assert property (!wr_ctrl |=> $stable(comparator_enable_o))
      else $error("enable moved without a write");
   ref_hold_a: assert property (!wr_ctrl |=> $stable(reference_select_o))
      else $error("reference select moved without a write");
   oe_hold_a: assert property (!wr_ctrl |=> $stable(comparator_out_pin_oe_o))
      else $error("pin enable moved without a write");

   // event detection
   flag_idle_a: assert property (!ctrl.enable && !compare_event_flag
                                 |=> !compare_event_flag)
      else $error("flag set while disabled");
   first_cycle_a: assert property (ctrl.enable && !en_d |-> !cmp_event)
      else $error("event in the first enabled cycle");
   filt_hold_a: assert property (sync[1] != sync[2] |=> $stable(filt))
      else $error("filtered level moved while stages disagree");
   rise_mode_a: assert property (ctrl.enable && en_d && rise &&
                                 ctrl.edge_sel == ccl_pkg::MODE_RISE |=> compare_event_flag)
      else $error("rising edge missed");
   both_mode_a: assert property (ctrl.enable && en_d && (rise || fall) &&
                                 ctrl.edge_sel == ccl_pkg::MODE_BOTH |=> compare_event_flag)
      else $error("edge missed in either-edge mode");
   fall_ignored_a: assert property (ctrl.edge_sel == ccl_pkg::MODE_RISE && fall
                                    |-> !cmp_event)
      else $error("falling edge counted in rising mode");

   // register writes
   sel_guard_a: assert property (wr_take && !req.sel[0] |=> $stable(ctrl))
      else $error("write without lane zero changed control");
   clear_ctrl_a: assert property (wr_ctrl && req.dat[ccl_pkg::FLAG_BIT]
                                  && !cmp_event |=> !compare_event_flag)
      else $error("flag not cleared through control");
   clear_istat_a: assert property (wr_istat && req.dat[ccl_pkg::ISTAT_EV_BIT]
                                   && !cmp_event |=> !compare_event_flag)
      else $error("flag not cleared through status");
   zero_keep_a: assert property (compare_event_flag && wr_ctrl &&
                                 !req.dat[ccl_pkg::FLAG_BIT] |=> compare_event_flag)
      else $error("writing zero cleared the flag");
   imask_write_a: assert property (wr_imask |=>
                                   ctrl.irq_en == $past(req.dat[ccl_pkg::ISTAT_EV_BIT]))
      else $error("mask write not taken");
   edge_write_a: assert property (wr_ctrl |=>
                                  ctrl.edge_sel == $past(req.dat[ccl_pkg::MODE_LSB +: 2]))
      else $error("event select write not taken");

   rise_event_c: cover property (ctrl.edge_sel == 2'h1 && cmp_event);
   both_event_c: cover property (ctrl.edge_sel == 2'h3 && fall && cmp_event);
   set_vs_clr_c: cover property (cmp_event && flag_clr);
   irq_seen_c:   cover property (irq_o ##[1:20] !irq_o);
   fall_event_c: cover property (ctrl.edge_sel == ccl_pkg::MODE_FALL2 && fall && cmp_event);
endmodule

// *** sim/ccl_comparator_model.sv ***
// behavioural analog comparator core at the far side of the control logic
`timescale 1ns/10ps
module ccl_comparator_model #(
   parameter logic [7:0] BANDGAP = 8'h80
) (
   input  wire logic       enable_i,
   input  wire logic       ref_sel_i,
   input  wire logic       inv_sel_i,
   input  wire logic [7:0] plus_i,
   input  wire logic [7:0] minus_i,
   output logic            level_o
);
   logic [7:0] noninv;
   assign noninv = ref_sel_i ? BANDGAP : plus_i;
   // a powered-down core decides nothing, so it gives a steady low
   assign level_o = enable_i && !inv_sel_i && (noninv > minus_i);
endmodule

// *** sim/tb.sv ***
// self-checking bench of the comparator control logic
`timescale 1ns/10ps
module tb;
   localparam logic [7:0] BG = 8'h80;
   logic                 clk_i = 1'b0;
   logic                 rst_i = 1'b1;
   ccl_pkg::ccl_wb_req_t rq = '0;
   logic [31:0]          wb_dat_o;
   logic                 wb_ack_o;
   logic                 cmp_level_i;
   logic                 en_o, ref_o, inv_o, pin_o, oe_o, irq_o;
   logic [7:0]           plus = 8'h10;
   logic [7:0]           minus = 8'h40;
   logic [7:0]           c = 8'h00;
   logic [31:0]          seed = 32'hefda5270;
   logic [31:0]          rd;
   int                   fail_count = 0;
   int                   n_compared = 0;
   int                   flg = 0;
   int                   lvl;
   always #25 clk_i = ~clk_i;
   ccl_top i_ccl_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(rq.cyc), .wb_stb_i(rq.stb),
      .wb_we_i(rq.we), .wb_sel_i(rq.sel), .wb_adr_i(rq.adr), .wb_dat_i(rq.dat),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cmp_level_i(cmp_level_i),
      .comparator_enable_o(en_o), .reference_select_o(ref_o), .inverting_select_o(inv_o),
      .comparator_out_pin_o(pin_o), .comparator_out_pin_oe_o(oe_o), .irq_o(irq_o));
   ccl_comparator_model #(.BANDGAP(BG)) i_ccl_comparator_model (.enable_i(en_o),
      .ref_sel_i(ref_o), .inv_sel_i(inv_o), .plus_i(plus), .minus_i(minus),
      .level_o(cmp_level_i));
   function automatic logic [31:0] xs(logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // the slave's latency is not assumed; only the watchdog ends a hang
   task automatic wb(logic we, logic [3:0] a, logic [7:0] d);
      rq <= '{1'b1, 1'b1, we, 4'hf, a, {24'h0, d}};
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1)
         @(posedge clk_i);
      rd = wb_dat_o;
      rq <= '0;
      @(posedge clk_i);
      chk("ack drop", wb_ack_o, 1'b0);
   endtask
   task automatic look(logic ie);
      lvl = c[7] && ((c[6] ? BG : plus) > minus);
      wb(1'b0, ccl_pkg::CTRL_OFS, 8'h00);
      chk("ctrl", rd, {24'h0, c[7:6], flg[0], ie, lvl[0], c[2:0]});
      chk("irq", irq_o, flg[0] & ie);
      chk("pins", {en_o, ref_o, inv_o, oe_o}, {c[7:6], 1'b0, c[2]});
      if (oe_o === 1'b1)
         chk("pin", pin_o, lvl[0]);
   endtask
   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      look(1'b0);
      for (int m = 0; m < 8; m++) begin
         c = {1'b1, 4'h0, m[2] ^ m[1], m[1:0]};
         wb(1'b1, ccl_pkg::CTRL_OFS, c | 8'h20 | {3'h0, m[2], 4'h0});
         repeat (8) @(posedge clk_i);
         wb(1'b1, ccl_pkg::CTRL_OFS, c | 8'h20 | {3'h0, m[2], 4'h0});
         wb(1'b1, ccl_pkg::IMASK_OFS, {7'h0, m[2]});
         flg = 0;
         look(m[2]);
         for (int k = 0; k < 2; k++) begin
            seed = xs(seed);
            // rise on the first pass, fall on the second
            plus <= (k == 0) ? minus + 8'h1 + 8'(seed % (255 - minus)) : 8'(seed % minus);
            if (m[1:0] == 2'h3 || (k == 0) == (m[1:0] == 2'h1))
               flg = 1;
            repeat (8) @(posedge clk_i);
            look(m[2]);
         end
         wb(1'b1, ccl_pkg::CTRL_OFS, c | {3'h0, m[2], 4'h0});
         look(m[2]);
         wb(1'b0, ccl_pkg::ISTAT_OFS, 8'h00);
         chk("istat", rd, flg);
         wb(1'b1, ccl_pkg::ISTAT_OFS, 8'h01);
         flg = 0;
         look(m[2]);
         $display("test mode %0d done", m);
      end
      c = 8'h07;
      wb(1'b1, ccl_pkg::CTRL_OFS, c | 8'h10);
      plus <= 8'hf0;
      repeat (8) @(posedge clk_i);
      look(1'b1);
      c = 8'hc0;
      wb(1'b1, ccl_pkg::CTRL_OFS, c);
      plus <= 8'h00;
      repeat (8) @(posedge clk_i);
      look(1'b0);
      wb(1'b0, 4'hc, 8'h00);
      chk("unmapped", rd, 32'h0);
      $display("test misc done");
      print_verdict();
   end
   initial begin
      repeat (5000) @(posedge clk_i);
      fail_count++;
      print_verdict();
   end
endmodule
